// File: hdl/fcl_fuse_config_loader.sv
// Fuse bank, processor read port, programming port and start-up loader.
// Assumes RST_B is the power-on reset and SYS_RST a same-clock level from
// the reset controller for every other reset source.
`timescale 1ns/100ps
`default_nettype none
module fcl_fuse_config_loader
   import fcl_pkg::*;
(
   input  wire logic               CLK,
   input  wire logic               RST_B,
   input  wire logic               SYS_RST,
   input  wire logic               CPU_RD,
   input  wire logic               CPU_WR,
   input  wire logic [FCL_AW-1:0]  CPU_ADDR,
   output logic      [7:0]         CPU_RDATA,
   output logic                    CPU_RVALID,
   output logic                    CPU_WERR,
   input  wire logic               PROG_REQ,
   input  wire fcl_pkg::fcl_cmd_t  PROG_CMD,
   input  wire logic [FCL_AW-1:0]  PROG_ADDR,
   input  wire logic [7:0]         PROG_WDATA,
   output logic      [7:0]         PROG_RDATA,
   output logic                    PROG_ACK,
   output logic                    PROG_ERR,
   output fcl_pkg::fcl_wdt_ctrl_t  WDT_CTRL,
   output fcl_pkg::fcl_bod_ctrl_t  BOD_CTRL,
   output fcl_pkg::fcl_osc_ctrl_t  OSC_CTRL,
   output logic                    DEVICE_LOCKED,
   output logic                    LOAD_DONE
);
   import fcl_pkg::*;

   typedef enum logic [4:0] {
      S_HOLD = 5'b00001,
      S_WDT  = 5'b00010,
      S_BOD  = 5'b00100,
      S_OSC  = 5'b01000,
      S_DONE = 5'b10000
   } fcl_state_t;

   fcl_state_t    state_q;
   fcl_state_t    state_d;
   logic          por_q;
   logic [7:0]    fuse_q [FCL_NUM_FUSES];
   logic          locked_q;
   logic          prog_seen_q;
   logic          ld_wdt;
   logic          ld_bod;
   logic          ld_osc;
   fcl_wdt_ctrl_t wdt_d;
   fcl_bod_ctrl_t bod_d;
   fcl_osc_ctrl_t osc_d;
   logic [7:0]    osc_fuse;
   logic          prog_ok;
   logic [7:0]    prog_mask;
   logic [8*FCL_NUM_FUSES-1:0] fuse_flat;

   // Writable mask of an offset; reserved offsets give zero
   function automatic logic [7:0] fcl_mask(input logic [FCL_AW-1:0] a);
      logic [7:0] m;
      m = FCL_MASK_NONE;
      if (a == FCL_OFS_WDT || a == FCL_OFS_BOD) begin
         m = FCL_MASK_FULL;
      end else if (a == FCL_OFS_OSC) begin
         m = FCL_MASK_OSC;
      end else if (a == FCL_OFS_SYS0) begin
         m = FCL_MASK_SYS0;
      end else if (a == FCL_OFS_SYS1) begin
         m = FCL_MASK_SYS1;
      end else if (a == FCL_OFS_APP_CODE_END_FUSE || a == FCL_OFS_BOOT || a == FCL_OFS_LOCK) begin
         m = FCL_MASK_FULL;
      end
      return m;
   endfunction : fcl_mask

   function automatic logic [7:0] fcl_factory(input int unsigned i);
      logic [7:0] v;
      v = FCL_RST_RSVD;
      case (i)
         0:       v = FCL_RST_WDT;
         1:       v = FCL_RST_BOD;
         2:       v = FCL_RST_OSC;
         5:       v = FCL_RST_SYS0;
         6:       v = FCL_RST_SYS1;
         7:       v = FCL_RST_APP_CODE_END_FUSE;
         8:       v = FCL_RST_BOOT;
         10:      v = FCL_RST_LOCK;
         default: v = FCL_RST_RSVD;
      endcase
      return v;
   endfunction : fcl_factory

   function automatic logic [7:0] fcl_read(input logic [FCL_AW-1:0] a,
                                           input logic [7:0] f [FCL_NUM_FUSES]);
      logic [7:0] v;
      v = 8'h00;
      if (a < FCL_AW'(FCL_NUM_FUSES)) begin
         v = f[a] & fcl_mask(a);
      end
      return v;
   endfunction : fcl_read

   // Loader sequence
   always_comb begin
      state_d = state_q;
      case (state_q)
         S_HOLD: begin
            if (!SYS_RST) begin
               state_d = S_WDT;
            end
         end
         S_WDT:   state_d = S_BOD;
         S_BOD:   state_d = S_OSC;
         S_OSC:   state_d = S_DONE;
         S_DONE: begin
            if (SYS_RST) begin
               state_d = S_HOLD;
            end
         end
         default: state_d = S_HOLD;
      endcase
      if (SYS_RST) begin
         state_d = S_HOLD;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_q <= S_HOLD;
      end else begin
         state_q <= state_d;
      end
   end

   // Power-on flag lives until the first load sequence has passed
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         por_q <= 1'b1;
      end else if (state_q == S_DONE) begin
         por_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         LOAD_DONE <= 1'b0;
      end else begin
         LOAD_DONE <= (state_q == S_OSC) || (state_q == S_DONE && !SYS_RST); // RL17
      end
   end

   // Target loads happen only inside the sequence
   assign ld_wdt   = (state_q == S_WDT); // RL6 RL7 RL4
   assign ld_bod   = (state_q == S_BOD) && por_q; // RL8
   assign ld_osc   = (state_q == S_OSC); // RL14
   assign osc_fuse = fuse_q[FCL_OFS_OSC];

   always_comb begin
      wdt_d.window      = fuse_q[FCL_OFS_WDT][FCL_WDT_WIN_LSB +: 4]; // RL6
      wdt_d.period      = fuse_q[FCL_OFS_WDT][FCL_WDT_PER_LSB +: 4]; // RL7
      bod_d.level       = fuse_q[FCL_OFS_BOD][FCL_BOD_THR_LSB +: 3]; // RL9
      bod_d.sample_rate = fuse_q[FCL_OFS_BOD][FCL_BOD_RATE_BIT]; // RL10
      bod_d.active_mode = fuse_q[FCL_OFS_BOD][FCL_BOD_ACT_LSB +: 2]; // RL11
      bod_d.sleep_mode  = fuse_q[FCL_OFS_BOD][FCL_BOD_SLP_LSB +: 2]; // RL12
      osc_d.cal_lock    = osc_fuse[FCL_OSC_LOCK_BIT]; // RL14
      osc_d.freq_choice = osc_fuse[FCL_OSC_FREQ_LSB +: 2];
      // Reserved frequency codes fall back to the 20 MHz calibration row
      osc_d.cal_row_20m = (osc_fuse[FCL_OSC_FREQ_LSB +: 2] != FCL_FREQ_16M); // RL15
   end

   fcl_field_reg #(
      .W   ($bits(fcl_wdt_ctrl_t)),
      .RST (FCL_WDT_CTRL_RST)
   ) u_wdt (
      .CLK   (CLK),
      .RST_B (RST_B),
      .LD    (ld_wdt),
      .D     (wdt_d),
      .Q     (WDT_CTRL)
   ); // RL3

   fcl_field_reg #(
      .W   ($bits(fcl_bod_ctrl_t)),
      .RST (FCL_BOD_CTRL_RST)
   ) u_bod (
      .CLK   (CLK),
      .RST_B (RST_B),
      .LD    (ld_bod),
      .D     (bod_d),
      .Q     (BOD_CTRL)
   ); // RL3

   fcl_field_reg #(
      .W   ($bits(fcl_osc_ctrl_t)),
      .RST (FCL_OSC_CTRL_RST)
   ) u_osc (
      .CLK   (CLK),
      .RST_B (RST_B),
      .LD    (ld_osc),
      .D     (osc_d),
      .Q     (OSC_CTRL)
   ); // RL3

   // Lock state is taken at load time; locked until first load
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         locked_q <= 1'b1;
      end else if (ld_osc) begin
         locked_q <= (fuse_q[FCL_OFS_LOCK] != FCL_LOCK_OPEN_KEY); // RL16
      end
   end

   assign DEVICE_LOCKED = locked_q;

   // Fuse bank; only the programming port may change it
   assign prog_ok   = PROG_REQ && !locked_q; // RL16
   assign prog_mask = fcl_mask(PROG_ADDR);

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         for (int unsigned i = 0; i < FCL_NUM_FUSES; i++) begin
            fuse_q[i] <= fcl_factory(i); // RL13
         end
      end else if (prog_ok && prog_mask != FCL_MASK_NONE) begin
         if (PROG_CMD == FCL_CMD_PROGRAM) begin
            fuse_q[PROG_ADDR] <= PROG_WDATA & prog_mask; // RL2 RL5
         end else if (PROG_CMD == FCL_CMD_CLEAR) begin
            fuse_q[PROG_ADDR] <= 8'h00; // RL2
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         prog_seen_q <= 1'b0;
      end else if (prog_ok && PROG_CMD != FCL_CMD_READ) begin
         prog_seen_q <= 1'b1;
      end
   end

   // Programming port answer
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PROG_ACK   <= 1'b0;
         PROG_ERR   <= 1'b0;
         PROG_RDATA <= 8'h00;
      end else begin
         PROG_ACK   <= PROG_REQ;
         PROG_ERR   <= PROG_REQ && (locked_q || prog_mask == FCL_MASK_NONE
                                    || PROG_CMD == 2'h3); // RL16
         PROG_RDATA <= (prog_ok && PROG_CMD == FCL_CMD_READ)
                       ? fcl_read(PROG_ADDR, fuse_q) : 8'h00;
      end
   end

   // Processor port: reads from power-up, writes refused
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CPU_RVALID <= 1'b0;
         CPU_WERR   <= 1'b0;
         CPU_RDATA  <= 8'h00;
      end else begin
         CPU_RVALID <= CPU_RD; // RL1
         CPU_WERR   <= CPU_WR; // RL2
         if (CPU_RD) begin
            CPU_RDATA <= fcl_read(CPU_ADDR, fuse_q); // RL1
         end
      end
   end

   // Packed view of the bank for the checks below
   always_comb begin
      for (int unsigned i = 0; i < FCL_NUM_FUSES; i++) begin
         fuse_flat[8*i +: 8] = fuse_q[i];
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   a_read_anytime: assert property (CPU_RD |=> CPU_RVALID // RL1
         && CPU_RDATA == $past(fuse_flat[8*CPU_ADDR +: 8] & fcl_mask(CPU_ADDR)))
      else $error("processor read answer wrong");
   a_cpu_no_write: assert property (CPU_WR && !PROG_REQ |=> // RL2
         $stable(fuse_flat) && CPU_WERR)
      else $error("processor write changed the bank");
   a_prog_answer: assert property (PROG_REQ |=> PROG_ACK) // RL2
      else $error("programming request not answered");
   a_cmd3_refused: assert property (PROG_REQ && PROG_CMD == 2'h3 |=> // RL2
         PROG_ERR && $stable(fuse_flat))
      else $error("illegal command accepted");
   a_load_sequence: assert property ($fell(SYS_RST) ##1 state_q == S_WDT // RL3
         |-> ##3 LOAD_DONE)
      else $error("load did not complete in time");
   a_target_hold: assert property (state_q == S_DONE ##1 state_q == S_DONE // RL4
         |-> $stable(WDT_CTRL) && $stable(BOD_CTRL) && $stable(OSC_CTRL))
      else $error("target changed outside the load");
   a_wdt_window: assert property (state_q == S_WDT |=> // RL6
         WDT_CTRL.window == $past(fuse_q[FCL_OFS_WDT][7:4]))
      else $error("watchdog window not loaded");
   a_wdt_period: assert property (state_q == S_WDT |=> // RL7
         WDT_CTRL.period == $past(fuse_q[FCL_OFS_WDT][3:0]))
      else $error("watchdog period not loaded");
   a_bod_keep: assert property (state_q == S_BOD && !por_q |=> $stable(BOD_CTRL)) // RL8
      else $error("brown-out changed on warm reset");
   a_bod_level: assert property (state_q == S_BOD && por_q |=> // RL9
         BOD_CTRL.level == $past(fuse_q[FCL_OFS_BOD][7:5]))
      else $error("brown-out level not loaded");
   a_bod_rate: assert property (state_q == S_BOD && por_q |=> // RL10
         BOD_CTRL.sample_rate == $past(fuse_q[FCL_OFS_BOD][4]))
      else $error("brown-out sample rate not loaded");
   a_bod_modes: assert property (state_q == S_BOD && por_q |=> // RL11
         BOD_CTRL.active_mode == $past(fuse_q[FCL_OFS_BOD][3:2]))
      else $error("brown-out awake mode not loaded");
   a_bod_sleep: assert property (state_q == S_BOD && por_q |=> // RL12
         BOD_CTRL.sleep_mode == $past(fuse_q[FCL_OFS_BOD][1:0]))
      else $error("brown-out sleep mode not loaded");
   a_factory_zero: assert property (!prog_seen_q |-> // RL13
         fuse_q[FCL_OFS_WDT] == 8'h00 && fuse_q[FCL_OFS_BOD] == 8'h00)
      else $error("factory value not zero");
   a_osc_lock: assert property (state_q == S_OSC |=> // RL14
         OSC_CTRL.cal_lock == $past(fuse_q[FCL_OFS_OSC][7]))
      else $error("oscillator lock not loaded");
   a_freq_row: assert property (state_q == S_OSC && fuse_q[FCL_OFS_OSC][1:0] == 2'h1 // RL15
         |=> !OSC_CTRL.cal_row_20m && OSC_CTRL.freq_choice == 2'h1)
      else $error("16 MHz row not chosen");
   a_lock_deny: assert property (PROG_REQ && locked_q |=> PROG_ERR // RL16
         && $stable(fuse_flat) && PROG_RDATA == 8'h00)
      else $error("locked device accepted access");
   a_done_after_osc: assert property ($rose(LOAD_DONE) |-> $past(state_q == S_OSC)) // RL17
      else $error("done raised before targets loaded");
   a_reserved_zero: assert property (PROG_REQ && !locked_q && PROG_CMD == FCL_CMD_PROGRAM // RL5
         && PROG_ADDR == FCL_OFS_OSC |=> (fuse_q[FCL_OFS_OSC] & ~FCL_MASK_OSC) == 8'h00)
      else $error("reserved bits stored");

   c_cold_load: cover property (state_q == S_BOD && por_q ##3 LOAD_DONE);
   c_warm_load: cover property (state_q == S_BOD && !por_q ##3 LOAD_DONE);
   c_prog_write: cover property (PROG_REQ && PROG_CMD == FCL_CMD_PROGRAM && !locked_q);
   c_locked_req: cover property (PROG_REQ && locked_q);
   c_row_16m: cover property (state_q == S_OSC && osc_fuse[FCL_OSC_FREQ_LSB +: 2] == FCL_FREQ_16M);

endmodule : fcl_fuse_config_loader
`default_nettype wire

// File: hdl/fcl_pkg.sv
// Constants, types and field layouts for the fuse configuration loader.
// Assumes one 100 MHz system clock and a reset controller on the same clock.
// Contract
// RL1 - Fuse bytes are readable from power-up, even while loading runs.
// RL2 - Processor only reads; programming interface reads, programs and clears.
// RL3 - At end of start-up each fuse value is copied to its target field.
// RL4 - Changed fuse values act only after a reset; targets hold until then.
// RL5 - Programming party drives reserved bits of each written byte to zero.
// RL6 - Every reset loads watchdog fuse bits 7:4 into window field.
// RL7 - Every reset loads watchdog fuse bits 3:0 into period field.
// RL8 - Brown-out targets reload only after power-on reset, else unchanged.
// RL9 - Brown-out fuse bits 7:5 load threshold level; 0, 2, 7 valid.
// RL10 - Brown-out fuse bit 4 loads sample rate: 0 is 1 kHz, 1 is 125 Hz.
// RL11 - Brown-out fuse bits 3:2 load the awake-mode field.
// RL12 - Brown-out fuse bits 1:0 load the low-power-mode field; code 3 reserved.
// RL13 - Watchdog and brown-out fuses leave the factory as 0x00.
// RL14 - Oscillator lock fuse bit is copied to the calibration lock bit.
// RL15 - Frequency choice 1 selects 16 MHz, 2 selects 20 MHz calibration.
// RL16 - Lock key 0xC5 means open; other values deny programming access.
// RL17 - Loader raises load-complete once all target fields are written.
package fcl_pkg;

   localparam int unsigned FCL_NUM_FUSES = 11;
   localparam int unsigned FCL_AW        = 4;

   localparam logic [3:0] FCL_OFS_WDT    = 4'h0;
   localparam logic [3:0] FCL_OFS_BOD    = 4'h1;
   localparam logic [3:0] FCL_OFS_OSC    = 4'h2;
   localparam logic [3:0] FCL_OFS_SYS0   = 4'h5;
   localparam logic [3:0] FCL_OFS_SYS1   = 4'h6;
   localparam logic [3:0] FCL_OFS_APP_CODE_END_FUSE = 4'h7;
   localparam logic [3:0] FCL_OFS_BOOT   = 4'h8;
   localparam logic [3:0] FCL_OFS_LOCK   = 4'hA;

   // Writable bit masks; zero bits are reserved
   localparam logic [7:0] FCL_MASK_FULL = 8'hFF;
   localparam logic [7:0] FCL_MASK_OSC  = 8'h83;
   localparam logic [7:0] FCL_MASK_SYS0 = 8'hC9;
   localparam logic [7:0] FCL_MASK_SYS1 = 8'h07;
   localparam logic [7:0] FCL_MASK_NONE = 8'h00;

   // Factory values of the bank
   localparam logic [7:0] FCL_RST_WDT    = 8'h00;
   localparam logic [7:0] FCL_RST_BOD    = 8'h00;
   localparam logic [7:0] FCL_RST_OSC    = 8'h02;
   localparam logic [7:0] FCL_RST_SYS0   = 8'hC0;
   localparam logic [7:0] FCL_RST_SYS1   = 8'h07;
   localparam logic [7:0] FCL_RST_APP_CODE_END_FUSE = 8'h00;
   localparam logic [7:0] FCL_RST_BOOT   = 8'h00;
   localparam logic [7:0] FCL_RST_LOCK   = 8'hC5;
   localparam logic [7:0] FCL_RST_RSVD   = 8'h00;

   localparam logic [7:0] FCL_LOCK_OPEN_KEY = 8'hC5;

   // Field positions
   localparam int unsigned FCL_WDT_WIN_LSB  = 4;
   localparam int unsigned FCL_WDT_PER_LSB  = 0;
   localparam int unsigned FCL_BOD_THR_LSB  = 5;
   localparam int unsigned FCL_BOD_RATE_BIT = 4;
   localparam int unsigned FCL_BOD_ACT_LSB  = 2;
   localparam int unsigned FCL_BOD_SLP_LSB  = 0;
   localparam int unsigned FCL_OSC_LOCK_BIT = 7;
   localparam int unsigned FCL_OSC_FREQ_LSB = 0;

   localparam logic [1:0] FCL_FREQ_16M = 2'h1;
   localparam logic [1:0] FCL_FREQ_20M = 2'h2;

   typedef enum logic [1:0] {
      FCL_CMD_READ    = 2'h0,
      FCL_CMD_PROGRAM = 2'h1,
      FCL_CMD_CLEAR   = 2'h2
   } fcl_cmd_t;

   typedef struct packed {
      logic [3:0] window;
      logic [3:0] period;
   } fcl_wdt_ctrl_t;

   typedef struct packed {
      logic [2:0] level;
      logic       sample_rate;
      logic [1:0] active_mode;
      logic [1:0] sleep_mode;
   } fcl_bod_ctrl_t;

   typedef struct packed {
      logic       cal_lock;
      logic [1:0] freq_choice;
      logic       cal_row_20m;
   } fcl_osc_ctrl_t;

   localparam fcl_wdt_ctrl_t FCL_WDT_CTRL_RST = 8'h00;
   localparam fcl_bod_ctrl_t FCL_BOD_CTRL_RST = 8'h00;
   localparam fcl_osc_ctrl_t FCL_OSC_CTRL_RST = 4'h5;

endpackage : fcl_pkg

// File: hdl/fcl_field_reg.sv
// Loadable target field register with a constant reset value.
// Assumes the load strobe comes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module fcl_field_reg #(
   parameter int unsigned       W   = 8,
   parameter logic [W-1:0]      RST = '0
) (
   input  wire logic         CLK,
   input  wire logic         RST_B,
   input  wire logic         LD,
   input  wire logic [W-1:0] D,
   output logic      [W-1:0] Q
);
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         Q <= RST;
      end else if (LD) begin
         Q <= D;
      end
   end
endmodule : fcl_field_reg
`default_nettype wire

// File: verif/fcl_prog_model.sv
// Model of the single-pin programming interface that drives the fuse port.
// Assumes calls are made just after a rising edge of CLK, one request each.
`timescale 1ns/100ps
`default_nettype none
module fcl_prog_model
   import fcl_pkg::*;
(
   input  wire logic              CLK,
   output logic                   PROG_REQ,
   output fcl_pkg::fcl_cmd_t      PROG_CMD,
   output logic      [FCL_AW-1:0] PROG_ADDR,
   output logic      [7:0]        PROG_WDATA,
   input  wire logic [7:0]        PROG_RDATA,
   input  wire logic              PROG_ACK,
   input  wire logic              PROG_ERR
);
   import fcl_pkg::*;

   initial begin
      PROG_REQ   = 1'b0;
      PROG_CMD   = FCL_CMD_READ;
      PROG_ADDR  = 4'hF;
      PROG_WDATA = 8'hA5;
   end

   // Writable bits of the OSC, SYS0 and SYS1 bytes; all ones for every other offset
   function automatic logic [7:0] wmask(input logic [3:0] o);
      case (o)
         FCL_OFS_OSC:  return FCL_MASK_OSC;
         FCL_OFS_SYS0: return FCL_MASK_SYS0;
         FCL_OFS_SYS1: return FCL_MASK_SYS1;
         default:      return FCL_MASK_FULL;
      endcase
   endfunction : wmask

   // One request; answer taken one edge later
   task automatic op(input fcl_cmd_t cmd, input logic [3:0] o, input logic [7:0] dat,
                     output logic ack, output logic err, output logic [7:0] rdat);
      PROG_REQ   = 1'b1;
      PROG_CMD   = cmd;
      PROG_ADDR  = o;
      PROG_WDATA = dat & wmask(o);
      @(posedge CLK);
      #1;
      ack  = PROG_ACK;
      err  = PROG_ERR;
      rdat = PROG_RDATA;
   endtask : op

   // Released address and data lines show no stale value
   task automatic idle();
      PROG_REQ   = 1'b0;
      PROG_ADDR  = ~PROG_ADDR;
      PROG_WDATA = ~PROG_WDATA;
   endtask : idle
endmodule : fcl_prog_model
`default_nettype wire

// File: verif/fcl_fuse_config_loader_tb_top.sv
// Self-checking bench for the fuse configuration loader.
// Assumes fcl_pkg and the programming-interface model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module fcl_fuse_config_loader_tb_top;
   import fcl_pkg::*;
   logic              clk, rst_b, sys_rst, cpu_rd, cpu_wr;
   logic [FCL_AW-1:0] cpu_addr, prog_addr;
   logic [7:0]        cpu_rdata, prog_wdata, prog_rdata, d, rd, bod_e;
   logic              cpu_rvalid, cpu_werr, prog_req, prog_ack, prog_err;
   logic              locked, load_done, ack, err;
   fcl_cmd_t          prog_cmd, c;
   fcl_wdt_ctrl_t     wdt;
   fcl_bod_ctrl_t     brownout_detector;
   fcl_osc_ctrl_t     osc;
   logic [7:0]        bank [16];
   logic [7:0]        ld [16];
   int                n_errors, n_checks, cyc, a, r, k;
   localparam logic [7:0] FACT [16] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'hC0, 8'h07,
      8'h00, 8'h00, 8'h00, 8'hC5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   fcl_fuse_config_loader i_fcl_fuse_config_loader (
      .CLK(clk), .RST_B(rst_b), .SYS_RST(sys_rst), .CPU_RD(cpu_rd), .CPU_WR(cpu_wr),
      .CPU_ADDR(cpu_addr), .CPU_RDATA(cpu_rdata), .CPU_RVALID(cpu_rvalid),
      .CPU_WERR(cpu_werr), .PROG_REQ(prog_req), .PROG_CMD(prog_cmd),
      .PROG_ADDR(prog_addr), .PROG_WDATA(prog_wdata), .PROG_RDATA(prog_rdata),
      .PROG_ACK(prog_ack), .PROG_ERR(prog_err), .WDT_CTRL(wdt), .BOD_CTRL(brownout_detector),
      .OSC_CTRL(osc), .DEVICE_LOCKED(locked), .LOAD_DONE(load_done));

   fcl_prog_model i_fcl_prog_model (
      .CLK(clk), .PROG_REQ(prog_req), .PROG_CMD(prog_cmd), .PROG_ADDR(prog_addr),
      .PROG_WDATA(prog_wdata), .PROG_RDATA(prog_rdata), .PROG_ACK(prog_ack),
      .PROG_ERR(prog_err));

   task automatic step();
      @(posedge clk);
      #1;
   endtask : step

   // Zero for reserved offsets, else the writable bits
   function automatic logic [7:0] wm(input logic [3:0] o);
      case (o)
         4'h2:    return 8'h83;
         4'h5:    return 8'hC9;
         4'h6:    return 8'h07;
         4'h3, 4'h4, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: return 8'h00;
         default: return 8'hFF;
      endcase
   endfunction : wm

   // Back-to-back processor reads over the whole window
   task automatic cpu_sweep();
      for (int i = 0; i < 16; i++) begin
         cpu_rd   = 1'b1;
         cpu_addr = i[3:0];
         step();
         `CHK("cpu_rvalid", 1'b1, cpu_rvalid)
         `CHK("cpu_rdata", bank[i], cpu_rdata)
      end
      cpu_rd   = 1'b0;
      cpu_addr = ~cpu_addr;
   endtask : cpu_sweep

   task automatic chk_targets();
      `CHK("wdt_window", ld[0][7:4], wdt.window)
      `CHK("wdt_period", ld[0][3:0], wdt.period)
      `CHK("bod_level", bod_e[7:5], brownout_detector.level)
      `CHK("bod_rate", bod_e[4], brownout_detector.sample_rate)
      `CHK("bod_active", bod_e[3:2], brownout_detector.active_mode)
      `CHK("bod_sleep", bod_e[1:0], brownout_detector.sleep_mode)
      `CHK("osc_lock", ld[2][7], osc.cal_lock)
      `CHK("osc_freq", ld[2][1:0], osc.freq_choice)
      `CHK("osc_row20", ld[2][1:0] != 2'h1, osc.cal_row_20m)
      `CHK("locked", ld[10] != 8'hC5, locked)
   endtask : chk_targets

   // Power-on or other reset, then the load sequence
   task automatic reload(input logic por);
      if (por) begin
         rst_b = 1'b0;
         repeat (10) step();
         rst_b = 1'b1;
         bank  = FACT;
         bod_e = FACT[1];
         cpu_sweep();
      end else begin
         sys_rst = 1'b1;
         step();
         sys_rst = 1'b0;
         `CHK("done_fall", 1'b0, load_done)
      end
      k = 0;
      while (load_done !== 1'b1 && k < 8) begin
         step();
         k++;
      end
      if (!por) `CHK("load_cycles", 4, k)
      `CHK("load_done", 1'b1, load_done)
      ld = bank;
      chk_targets();
   endtask : reload

   task automatic tally_and_finish();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc > 5000) begin
         n_errors++;
         tally_and_finish();
      end
   end

   initial begin
      {rst_b, sys_rst, cpu_rd, cpu_wr, cpu_addr} = '0;
      n_errors = 0;
      n_checks = 0;
      k = $urandom(32'h1ecd);
      reload(1'b1);
      cpu_wr   = 1'b1;
      cpu_addr = FCL_OFS_WDT;
      step();
      cpu_wr   = 1'b0;
      `CHK("cpu_werr", 1'b1, cpu_werr)
      for (r = 0; r < 3; r++) begin
         for (a = 0; a < 16; a++) begin
            d = (a == 10) ? 8'hC5 : (a == 2 && r == 0) ? 8'h81 : 8'($urandom);
            c = FCL_CMD_PROGRAM;
            if (r == 1 && a[0]) c = FCL_CMD_CLEAR;
            i_fcl_prog_model.op(c, a[3:0], d, ack, err, rd);
            `CHK("prog_ack", 1'b1, ack)
            `CHK("prog_err", wm(a[3:0]) == 8'h00, err)
            if (wm(a[3:0]) != 8'h00) bank[a] = (c == FCL_CMD_CLEAR) ? 8'h00 : d & wm(a[3:0]);
            i_fcl_prog_model.op(FCL_CMD_READ, a[3:0], 8'h00, ack, err, rd);
            `CHK("prog_rdata", bank[a], rd)
         end
         i_fcl_prog_model.idle();
         `CHK("wdt_held", ld[0], wdt)
         cpu_sweep();
         reload(1'b0);
         `CHK("bod_kept", bod_e, brownout_detector)
      end
      i_fcl_prog_model.op(fcl_cmd_t'(2'h3), FCL_OFS_WDT, 8'h00, ack, err, rd);
      `CHK("cmd3_err", 1'b1, err)
      d = 8'($urandom);
      if (d == 8'hC5) d = 8'h00;
      i_fcl_prog_model.op(FCL_CMD_PROGRAM, FCL_OFS_LOCK, d, ack, err, rd);
      i_fcl_prog_model.idle();
      bank[10] = d;
      reload(1'b0);
      i_fcl_prog_model.op(FCL_CMD_CLEAR, FCL_OFS_WDT, 8'h00, ack, err, rd);
      `CHK("lock_err", 1'b1, err)
      i_fcl_prog_model.op(FCL_CMD_READ, FCL_OFS_WDT, 8'h00, ack, err, rd);
      `CHK("lock_rdata", 8'h00, rd)
      i_fcl_prog_model.idle();
      cpu_sweep();
      reload(1'b1);
      tally_and_finish();
   end
endmodule : fcl_fuse_config_loader_tb_top
`default_nettype wire
